/* rtl/pgb_gen_bc_cfg.sv */
// pgb_gen_bc_cfg: AXI4-Lite register file and generator B timing core,
// plus the generator C enable / load-okay / reload-irq-enable control.
// assumes generator C's counter lives elsewhere and reports its reload
// and flag through reloadC and reloadFlagC, synchronous to clk.
//
// Our own choice: the AXI4-Lite register port.
`timescale 1ns/1ps
module pgb_gen_bc_cfg
	import pgb_pkg::*;
#(
	parameter int AW = 8
) (
	input  wire logic          clk,
	input  wire logic          rst,
	input  wire logic [AW-1:0] s_axi_awaddr,
	input  wire logic          s_axi_awvalid,
	output logic               s_axi_awready,
	input  wire logic [31:0]   s_axi_wdata,
	input  wire logic [3:0]    s_axi_wstrb,
	input  wire logic          s_axi_wvalid,
	output logic               s_axi_wready,
	output logic [1:0]         s_axi_bresp,
	output logic               s_axi_bvalid,
	input  wire logic          s_axi_bready,
	input  wire logic [AW-1:0] s_axi_araddr,
	input  wire logic          s_axi_arvalid,
	output logic               s_axi_arready,
	output logic [31:0]        s_axi_rdata,
	output logic [1:0]         s_axi_rresp,
	output logic               s_axi_rvalid,
	input  wire logic          s_axi_rready,
	input  wire logic          reloadC,
	input  wire logic          reloadFlagC,
	output logic               multiGenSelect,
	output logic [1:0]         prescaleActB,
	output logic [14:0]        modulusActB,
	output logic [14:0]        counterB,
	output logic               reloadB,
	output logic               reloadReqB,
	output logic [14:0]        deadtimeCyclesB,
	output logic               genCEnable,
	output logic               genCLoad,
	output logic               reloadIrqC
);
	// -------------------------------------------------------------
	// state
	// -------------------------------------------------------------
	logic          awHeld_ff, nxt_awHeld, wHeld_ff, nxt_wHeld;
	logic [AW-1:0] awAddr_ff, nxt_awAddr;
	logic [31:0]   wData_ff, nxt_wData;
	logic [3:0]    wStrb_ff, nxt_wStrb;
	logic          bvalid_ff, nxt_bvalid, rvalid_ff, nxt_rvalid;
	logic [1:0]    bresp_ff, nxt_bresp, rresp_ff, nxt_rresp;
	logic [31:0]   rdata_ff, nxt_rdata;
	logic          mtg_ff, nxt_mtg, wp_ff, nxt_wp, edge_ff, nxt_edge;
	logic          load_okay_b_ff, nxt_load_okay_b, ldokBArm_ff, nxt_ldokBArm;
	logic [3:0]    freqBuf_ff, nxt_freqBuf, freqAct_ff, nxt_freqAct;
	logic          half_ff, nxt_half;
	logic [1:0]    pscBuf_ff, nxt_pscBuf, pscAct_ff, nxt_pscAct;
	logic          flag_ff, nxt_flag, flagArm_ff, nxt_flagArm;
	logic [14:0]   modBuf_ff, nxt_modBuf, modAct_ff, nxt_modAct;
	logic [11:0]   dtm_ff, nxt_dtm;
	logic [14:0]   dtCyc_ff, nxt_dtCyc;
	logic [2:0]    div_ff, nxt_div;
	logic [14:0]   cnt_ff, nxt_cnt;
	logic          down_ff, nxt_down;
	logic [3:0]    opp_ff, nxt_opp;
	logic          reload_ff, nxt_reload;
	logic          enC_ff, nxt_enC, rieC_ff, nxt_rieC;
	logic          load_okay_c_ff, nxt_load_okay_c, ldokCArm_ff, nxt_ldokCArm;
	logic          cLoad_ff, nxt_cLoad;

	// -------------------------------------------------------------
	// helpers
	// -------------------------------------------------------------
	function automatic logic [15:0] mergeBytes(
		input logic [15:0] old,
		input logic [31:0] data,
		input logic [3:0]  strb
	);
		logic [15:0] res;
		res = old;
		if (strb[0]) begin
			res[7:0] = data[7:0];
		end
		if (strb[1]) begin
			res[15:8] = data[15:8];
		end
		return res;
	endfunction

	function automatic logic [2:0] pscMask(input logic [1:0] psc);
		logic [2:0] m;
		unique case (psc)
			2'h0: m = 3'h0;
			2'h1: m = 3'h1;
			2'h2: m = 3'h3;
			2'h3: m = 3'h7;
		endcase
		return m;
	endfunction

	// divisor * value - 1, or the value itself when the divisor is one
	function automatic logic [14:0] dtCycles(
		input logic [11:0] dt,
		input logic [1:0]  psc
	);
		logic [14:0] prod;
		prod = 15'({3'h0, dt} << psc);
		if (psc == 2'h0) begin
			return prod;
		end
		return 15'(prod - 15'h0001);
	endfunction

	// -------------------------------------------------------------
	// combinational decode
	// -------------------------------------------------------------
	logic        awHs, wHs, arHs, doWrite, wrHit, rdHit;
	logic [5:0]  wIdx, rIdx;
	logic [15:0] wVal, fqcRd;
	logic        tick, fullOpp, halfOpp, oppEv, reloadNow;

	assign s_axi_awready = !awHeld_ff && !bvalid_ff;
	assign s_axi_wready  = !wHeld_ff && !bvalid_ff;
	assign s_axi_arready = !rvalid_ff;
	assign awHs    = s_axi_awvalid && s_axi_awready;
	assign wHs     = s_axi_wvalid && s_axi_wready;
	assign arHs    = s_axi_arvalid && s_axi_arready;
	assign doWrite = awHeld_ff && wHeld_ff && !bvalid_ff;
	assign wIdx    = awAddr_ff[7:2];
	assign rIdx    = s_axi_araddr[7:2];
	assign fqcRd   = {8'h00, freqBuf_ff, half_ff, pscBuf_ff, flag_ff};
	assign tick    = (div_ff & pscMask(pscAct_ff)) == pscMask(pscAct_ff);

	always_comb begin
		nxt_awHeld   = awHeld_ff;
		nxt_awAddr   = awAddr_ff;
		nxt_wHeld    = wHeld_ff;
		nxt_wData    = wData_ff;
		nxt_wStrb    = wStrb_ff;
		nxt_bvalid   = bvalid_ff;
		nxt_bresp    = bresp_ff;
		nxt_rvalid   = rvalid_ff;
		nxt_rresp    = rresp_ff;
		nxt_rdata    = rdata_ff;
		nxt_mtg      = mtg_ff;
		nxt_wp       = wp_ff;
		nxt_edge     = edge_ff;
		nxt_load_okay_b    = load_okay_b_ff;
		nxt_ldokBArm = ldokBArm_ff;
		nxt_freqBuf  = freqBuf_ff;
		nxt_freqAct  = freqAct_ff;
		nxt_half     = half_ff;
		nxt_pscBuf   = pscBuf_ff;
		nxt_pscAct   = pscAct_ff;
		nxt_flag     = flag_ff;
		nxt_flagArm  = flagArm_ff;
		nxt_modBuf   = modBuf_ff;
		nxt_modAct   = modAct_ff;
		nxt_dtm      = dtm_ff;
		nxt_enC      = enC_ff;
		nxt_rieC     = rieC_ff;
		nxt_load_okay_c    = load_okay_c_ff;
		nxt_ldokCArm = ldokCArm_ff;
		nxt_div      = 3'(div_ff + 3'h1);
		nxt_cnt      = cnt_ff;
		nxt_down     = down_ff;
		nxt_opp      = opp_ff;
		fullOpp      = 1'b0;
		halfOpp      = 1'b0;
		wrHit        = 1'b0;
		rdHit        = 1'b0;
		wVal         = 16'h0000;

		// ---------------------------------------------------------
		// generator B counter
		// ---------------------------------------------------------
		if (!mtg_ff) begin
			nxt_cnt  = 15'h0000;
			nxt_down = 1'b0;
		end else if (tick) begin
			if (edge_ff) begin
				if (cnt_ff >= modAct_ff) begin
					nxt_cnt = 15'h0001;
					fullOpp = 1'b1;
				end else begin
					nxt_cnt = 15'(cnt_ff + 15'h0001);
				end
			end else if (!down_ff) begin
				if (cnt_ff >= modAct_ff) begin
					nxt_down = 1'b1;
					nxt_cnt  = 15'(modAct_ff - 15'h0001);
					halfOpp  = 1'b1;
				end else begin
					nxt_cnt = 15'(cnt_ff + 15'h0001);
				end
			end else if (cnt_ff == 15'h0000) begin
				nxt_down = 1'b0;
				nxt_cnt  = 15'h0001;
				fullOpp  = 1'b1;
			end else begin
				nxt_cnt = 15'(cnt_ff - 15'h0001);
			end
		end
		// half-cycle reloads only exist in center-aligned mode
		oppEv     = fullOpp || (halfOpp && half_ff && !edge_ff);
		reloadNow = oppEv && (opp_ff == freqAct_ff);
		if (oppEv) begin
			nxt_opp = reloadNow ? 4'h0 : 4'(opp_ff + 4'h1);
		end

		// ---------------------------------------------------------
		// read channel; reads arm the clear / set sequences
		// ---------------------------------------------------------
		if (s_axi_rvalid && s_axi_rready) begin
			nxt_rvalid = 1'b0;
		end
		if (arHs) begin
			nxt_rvalid = 1'b1;
			rdHit      = 1'b1;
			nxt_rdata  = 32'h0000_0000;
			unique case (rIdx)
				IDX_CTRL: nxt_rdata[3:0] = {edge_ff, load_okay_b_ff, wp_ff, mtg_ff};
				IDX_FQC_B: begin
					nxt_rdata[15:0] = fqcRd;
					if (flag_ff) begin
						nxt_flagArm = 1'b1;
					end
				end
				IDX_CNT_B: nxt_rdata[14:0] = cnt_ff;
				IDX_MOD_B: nxt_rdata[14:0] = modBuf_ff;
				IDX_DTM_B: nxt_rdata[11:0] = dtm_ff;
				IDX_ENC_C: begin
					// bits hidden while generator C does not exist
					nxt_rdata[ENC_EN_BIT]   = enC_ff && mtg_ff;
					nxt_rdata[ENC_LDOK_BIT] = load_okay_c_ff && mtg_ff;
					nxt_rdata[ENC_RIE_BIT]  = rieC_ff && mtg_ff;
					if (mtg_ff && !load_okay_c_ff) begin
						nxt_ldokCArm = 1'b1;
					end
				end
				default: rdHit = 1'b0;
			endcase
			if (rIdx == IDX_CTRL && !load_okay_b_ff) begin
				nxt_ldokBArm = 1'b1;
			end
			if (s_axi_araddr[1:0] != 2'h0) begin
				rdHit = 1'b0;
			end
			nxt_rresp = rdHit ? RESP_OKAY : RESP_SLVERR;
		end

		// ---------------------------------------------------------
		// write channel
		// ---------------------------------------------------------
		if (awHs) begin
			nxt_awHeld = 1'b1;
			nxt_awAddr = s_axi_awaddr;
		end
		if (wHs) begin
			nxt_wHeld = 1'b1;
			nxt_wData = s_axi_wdata;
			nxt_wStrb = s_axi_wstrb;
		end
		if (s_axi_bvalid && s_axi_bready) begin
			nxt_bvalid = 1'b0;
		end
		if (doWrite) begin
			nxt_awHeld = 1'b0;
			nxt_wHeld  = 1'b0;
			nxt_bvalid = 1'b1;
			wrHit      = 1'b1;
			unique case (wIdx)
				IDX_CTRL: begin
					wVal     = mergeBytes({12'h000, edge_ff, load_okay_b_ff, wp_ff,
						mtg_ff}, wData_ff, wStrb_ff);
					nxt_mtg  = wVal[CTRL_MTG_BIT];
					nxt_edge = wVal[CTRL_EDGE_BIT];
					// write protect is sticky until reset
					nxt_wp   = wp_ff || wVal[CTRL_WP_BIT];
					if (!wVal[CTRL_LDOK_BIT]) begin
						nxt_load_okay_b = 1'b0;
					end else if (ldokBArm_ff) begin
						nxt_load_okay_b = 1'b1;
					end
					nxt_ldokBArm = 1'b0;
				end
				IDX_FQC_B: if (mtg_ff && wStrb_ff[0]) begin
					nxt_freqBuf = wData_ff[FQC_FREQ_LSB +: 4];
					nxt_half    = wData_ff[FQC_HALF_BIT];
					nxt_pscBuf  = wData_ff[FQC_PSC_LSB +: 2];
					// a reload in between disarms, so the write is void
					if (wData_ff[FQC_FLAG_BIT] && flagArm_ff) begin
						nxt_flag    = 1'b0;
						nxt_flagArm = 1'b0;
					end
				end
				IDX_CNT_B: ;
				IDX_MOD_B: if (mtg_ff) begin
					wVal       = mergeBytes({1'b0, modBuf_ff}, wData_ff,
						wStrb_ff);
					nxt_modBuf = wVal[14:0];
				end
				IDX_DTM_B: if (mtg_ff && !wp_ff) begin
					wVal    = mergeBytes({4'h0, dtm_ff}, wData_ff, wStrb_ff);
					nxt_dtm = wVal[11:0];
				end
				IDX_ENC_C: if (mtg_ff && wStrb_ff[0]) begin
					nxt_enC  = wData_ff[ENC_EN_BIT];
					nxt_rieC = wData_ff[ENC_RIE_BIT];
					if (!wData_ff[ENC_LDOK_BIT]) begin
						nxt_load_okay_c = 1'b0;
					end else if (ldokCArm_ff) begin
						nxt_load_okay_c = 1'b1;
					end
					nxt_ldokCArm = 1'b0;
				end
				default: wrHit = 1'b0;
			endcase
			if (awAddr_ff[1:0] != 2'h0) begin
				wrHit = 1'b0;
			end
			nxt_bresp = wrHit ? RESP_OKAY : RESP_SLVERR;
		end

		// ---------------------------------------------------------
		// reload events win over software clears
		// ---------------------------------------------------------
		if (reloadNow) begin
			nxt_freqAct = freqBuf_ff;
			nxt_flag    = 1'b1;
			nxt_flagArm = 1'b0;
			if (load_okay_b_ff) begin
				nxt_pscAct = pscBuf_ff;
				nxt_modAct = modBuf_ff;
				nxt_load_okay_b  = 1'b0;
				nxt_div    = 3'h0;
			end
		end
		if (reloadC && load_okay_c_ff) begin
			nxt_load_okay_c = 1'b0;
		end
	end

	assign nxt_reload = reloadNow;
	assign nxt_dtCyc  = dtCycles(dtm_ff, pscAct_ff);
	assign nxt_cLoad  = reloadC && load_okay_c_ff && mtg_ff;

	// -------------------------------------------------------------
	// registers
	// -------------------------------------------------------------
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			awHeld_ff <= 1'b0;  awAddr_ff <= '0;  wHeld_ff <= 1'b0;
			wData_ff <= 32'h0000_0000;  wStrb_ff <= 4'h0;
			bvalid_ff <= 1'b0;  bresp_ff <= RESP_OKAY;
			rvalid_ff <= 1'b0;  rresp_ff <= RESP_OKAY;
			rdata_ff <= 32'h0000_0000;
			mtg_ff <= 1'b0;  wp_ff <= 1'b0;  edge_ff <= 1'b0;
			load_okay_b_ff <= 1'b0;  ldokBArm_ff <= 1'b0;
			freqBuf_ff <= FREQ_RST;  freqAct_ff <= FREQ_RST;
			half_ff <= 1'b0;  pscBuf_ff <= PSC_RST;  pscAct_ff <= PSC_RST;
			flag_ff <= 1'b0;  flagArm_ff <= 1'b0;
			modBuf_ff <= MOD_RST;  modAct_ff <= MOD_RST;
			dtm_ff <= DTM_RST;  dtCyc_ff <= 15'(DTM_RST);
			div_ff <= 3'h0;  cnt_ff <= 15'h0000;  down_ff <= 1'b0;
			opp_ff <= 4'h0;  reload_ff <= 1'b0;
			enC_ff <= 1'b0;  rieC_ff <= 1'b0;
			load_okay_c_ff <= 1'b0;  ldokCArm_ff <= 1'b0;  cLoad_ff <= 1'b0;
		end else begin
			awHeld_ff <= nxt_awHeld;  awAddr_ff <= nxt_awAddr;
			wHeld_ff <= nxt_wHeld;  wData_ff <= nxt_wData;
			wStrb_ff <= nxt_wStrb;  bvalid_ff <= nxt_bvalid;
			bresp_ff <= nxt_bresp;  rvalid_ff <= nxt_rvalid;
			rresp_ff <= nxt_rresp;  rdata_ff <= nxt_rdata;
			mtg_ff <= nxt_mtg;  wp_ff <= nxt_wp;  edge_ff <= nxt_edge;
			load_okay_b_ff <= nxt_load_okay_b;  ldokBArm_ff <= nxt_ldokBArm;
			freqBuf_ff <= nxt_freqBuf;  freqAct_ff <= nxt_freqAct;
			half_ff <= nxt_half;  pscBuf_ff <= nxt_pscBuf;
			pscAct_ff <= nxt_pscAct;  flag_ff <= nxt_flag;
			flagArm_ff <= nxt_flagArm;  modBuf_ff <= nxt_modBuf;
			modAct_ff <= nxt_modAct;  dtm_ff <= nxt_dtm;
			dtCyc_ff <= nxt_dtCyc;  div_ff <= nxt_div;  cnt_ff <= nxt_cnt;
			down_ff <= nxt_down;  opp_ff <= nxt_opp;
			reload_ff <= nxt_reload;  enC_ff <= nxt_enC;
			rieC_ff <= nxt_rieC;  load_okay_c_ff <= nxt_load_okay_c;
			ldokCArm_ff <= nxt_ldokCArm;  cLoad_ff <= nxt_cLoad;
		end
	end

	// -------------------------------------------------------------
	// outputs
	// -------------------------------------------------------------
	assign s_axi_bvalid    = bvalid_ff;
	assign s_axi_bresp     = bresp_ff;
	assign s_axi_rvalid    = rvalid_ff;
	assign s_axi_rresp     = rresp_ff;
	assign s_axi_rdata     = rdata_ff;
	assign multiGenSelect  = mtg_ff;
	assign prescaleActB    = pscAct_ff;
	assign modulusActB     = modAct_ff;
	assign counterB        = cnt_ff;
	assign reloadB         = reload_ff;
	assign reloadReqB      = flag_ff;
	assign deadtimeCyclesB = dtCyc_ff;
	assign genCEnable      = enC_ff && mtg_ff;
	assign genCLoad        = cLoad_ff;
	assign reloadIrqC      = reloadFlagC && rieC_ff && mtg_ff;

	// -------------------------------------------------------------
	// checks
	// -------------------------------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	AST_WR_GATED: assert property (
		doWrite && !mtg_ff && wIdx == IDX_MOD_B |=> $stable(modBuf_ff))
		else $error("modulus written without select");
	AST_RELOAD_FLAG: assert property (
		reloadNow |=> flag_ff && reloadB)
		else $error("reload did not set flag");
	AST_FREQ_ACT: assert property (
		reloadNow |=> freqAct_ff == $past(freqBuf_ff))
		else $error("reload frequency not applied");
	AST_PSC_HOLD: assert property (
		!load_okay_b_ff && reloadNow |=> $stable(pscAct_ff))
		else $error("prescaler applied without load okay");
	AST_MOD_LOAD: assert property (
		load_okay_b_ff && reloadNow
		|=> modAct_ff == $past(modBuf_ff) && !load_okay_b_ff)
		else $error("modulus not loaded at reload");
	AST_FLAG_CLR: assert property (
		$fell(flag_ff) |-> $past(flagArm_ff) && $past(doWrite))
		else $error("flag cleared without sequence");
	AST_WP: assert property (
		wp_ff |=> $stable(dtm_ff))
		else $error("deadtime changed under write protect");
	// the registered count follows the prescaler of the cycle before
	AST_DT: assert property (
		##1 dtCyc_ff == ($past(pscAct_ff) == 2'h0 ? 15'($past(dtm_ff))
		: 15'(({3'h0, $past(dtm_ff)} << $past(pscAct_ff)) - 15'h0001)))
		else $error("deadtime cycles wrong");
	AST_C_HIDDEN: assert property (
		!mtg_ff |-> !genCEnable && !reloadIrqC)
		else $error("generator C visible without select");
	AST_C_LDOK: assert property (
		reloadC && load_okay_c_ff
		|=> !load_okay_c_ff && genCLoad == $past(mtg_ff))
		else $error("C load okay not consumed");
	AST_CNT_RANGE: assert property (
		mtg_ff && edge_ff && tick && cnt_ff >= modAct_ff
		|=> cnt_ff == 15'h0001) else $error("edge counter wrap wrong");

	COV_RELOAD_LOAD: cover property (load_okay_b_ff && reloadNow);
	COV_FLAG_CLEAR:  cover property (flag_ff ##1 !flag_ff);
	COV_HALF:        cover property (halfOpp && half_ff && !edge_ff);
	COV_C_LOAD:      cover property (genCLoad);
endmodule

/* rtl/pgb_pkg.sv */
// pgb_pkg: register map, field layout and reset values of the
// generator B / C configuration block.
// assumes byte addresses equal four times the register index.
package pgb_pkg;
	// -------------------------------------------------------------
	// register indexes (byte address = 4 * index)
	// -------------------------------------------------------------
	localparam logic [5:0] IDX_CTRL     = 6'h20;
	localparam logic [5:0] IDX_FQC_B    = 6'h29;
	localparam logic [5:0] IDX_CNT_B    = 6'h2A;
	localparam logic [5:0] IDX_MOD_B    = 6'h2C;
	localparam logic [5:0] IDX_DTM_B    = 6'h2E;
	localparam logic [5:0] IDX_ENC_C    = 6'h30;
	// -------------------------------------------------------------
	// field positions
	// -------------------------------------------------------------
	localparam int CTRL_MTG_BIT  = 0;
	localparam int CTRL_WP_BIT   = 1;
	localparam int CTRL_LDOK_BIT = 2;
	localparam int CTRL_EDGE_BIT = 3;
	localparam int FQC_FREQ_LSB  = 4;
	localparam int FQC_HALF_BIT  = 3;
	localparam int FQC_PSC_LSB   = 1;
	localparam int FQC_FLAG_BIT  = 0;
	localparam int ENC_EN_BIT    = 7;
	localparam int ENC_LDOK_BIT  = 1;
	localparam int ENC_RIE_BIT   = 0;
	// -------------------------------------------------------------
	// reset values
	// -------------------------------------------------------------
	localparam logic [14:0] MOD_RST  = 15'h7FFF;
	localparam logic [11:0] DTM_RST  = 12'hFFF;
	localparam logic [3:0]  FREQ_RST = 4'h0;
	localparam logic [1:0]  PSC_RST  = 2'h0;
	// -------------------------------------------------------------
	// bus responses
	// -------------------------------------------------------------
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

/* sim/pgb_gen_bc_cfg_tb.sv */
// pgb_gen_bc_cfg_tb: self-checking bench for the generator B / C config
// block, acting as a single AXI4-Lite master with sequenced calls.
// assumes generator B runs edge-aligned, then center-aligned at the end; reload timing is measured.
`timescale 1ns/1ps
module pgb_gen_bc_cfg_tb import pgb_pkg::*;;
	localparam int LIMIT = 60000;
	logic        clk, rst, awValid, wValid, bReady, arValid, rReady;
	logic        awReady, wReady, bValid, arReady, rValid, reloadC;
	logic        reloadFlagC, multiGenSelect, reloadB, reloadReqB;
	logic        genCEnable, genCLoad, reloadIrqC;
	logic [7:0]  awAddr, arAddr;
	logic [31:0] wData, rData, d;
	logic [3:0]  wStrb;
	logic [1:0]  bResp, rResp, r, prescaleActB;
	logic [14:0] modulusActB, counterB, deadtimeCyclesB;
	int          fails, nTests, cyc, n;

	pgb_gen_bc_cfg dut (.clk(clk), .rst(rst), .s_axi_awaddr(awAddr),
		.s_axi_awvalid(awValid), .s_axi_awready(awReady),
		.s_axi_wdata(wData), .s_axi_wstrb(wStrb), .s_axi_wvalid(wValid),
		.s_axi_wready(wReady), .s_axi_bresp(bResp), .s_axi_bvalid(bValid),
		.s_axi_bready(bReady), .s_axi_araddr(arAddr),
		.s_axi_arvalid(arValid), .s_axi_arready(arReady),
		.s_axi_rdata(rData), .s_axi_rresp(rResp), .s_axi_rvalid(rValid),
		.s_axi_rready(rReady), .reloadC(reloadC), .reloadFlagC(reloadFlagC),
		.multiGenSelect(multiGenSelect), .prescaleActB(prescaleActB),
		.modulusActB(modulusActB), .counterB(counterB), .reloadB(reloadB),
		.reloadReqB(reloadReqB), .deadtimeCyclesB(deadtimeCyclesB),
		.genCEnable(genCEnable), .genCLoad(genCLoad),
		.reloadIrqC(reloadIrqC));

	// ---------------------------------------------------------------
	// clock, watchdog and verdict
	// ---------------------------------------------------------------
	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end

	task automatic stop_test;
		if (fails == 0 && nTests > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask

	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == LIMIT) begin
			fails++;
			stop_test();
		end
	end

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		nTests++;
		if (got !== exp) begin
			fails++;
			$display("mismatch at %0t: got %h exp %h", $time, got, exp);
		end
	endtask

	// ---------------------------------------------------------------
	// bus tasks: entered just after a rising edge, sample ready at the
	// falling edge so the handshake edge is known without a race
	// ---------------------------------------------------------------
	task automatic axWr(input logic [5:0] idx, input logic [31:0] v);
		logic aT, wT, bV;
		bV = 1'b0;
		awAddr <= {idx, 2'b00};
		wData <= v;
		awValid <= 1'b1;
		wValid <= 1'b1;
		while (!bV) begin
			@(negedge clk);
			aT = awValid && awReady;
			wT = wValid && wReady;
			bV = bValid;
			r = bResp;
			@(posedge clk);
			if (aT) awValid <= 1'b0;
			if (wT) wValid <= 1'b0;
		end
	endtask

	task automatic axRd(input logic [5:0] idx);
		logic aT, rV;
		rV = 1'b0;
		arAddr <= {idx, 2'b00};
		arValid <= 1'b1;
		while (!rV) begin
			@(negedge clk);
			aT = arValid && arReady;
			rV = rValid;
			d = rData;
			r = rResp;
			@(posedge clk);
			if (aT) arValid <= 1'b0;
		end
	endtask

	task automatic wr(input logic [5:0] idx, input logic [31:0] v);
		axWr(idx, v);
		chk(32'(r), 32'(RESP_OKAY));
	endtask

	task automatic rdChk(input logic [5:0] idx, input logic [31:0] exp);
		axRd(idx);
		chk(d, exp);
	endtask

	// outputs are compared mid-cycle, once the registered values settled
	task automatic settle;
		repeat (2) @(posedge clk);
		@(negedge clk);
	endtask

	task automatic waitRel;
		do @(negedge clk); while (reloadB !== 1'b1);
		@(posedge clk);
	endtask

	task automatic period;
		waitRel();
		n = 0;
		do begin
			@(negedge clk);
			n++;
		end while (reloadB !== 1'b1);
		@(posedge clk);
	endtask

	// ---------------------------------------------------------------
	// main sequence
	// ---------------------------------------------------------------
	initial begin
		// response readies stay high, so back-to-back calls never retoggle
		{rst, awValid, wValid, bReady, arValid, rReady} = 6'h25;
		{reloadC, reloadFlagC, fails, nTests, cyc} = '0;
		{awAddr, arAddr, wData, wStrb} = {16'h0000, 32'h0, 4'h3};
		repeat (12) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		rdChk(IDX_DTM_B, 32'h0000_0FFF);
		rdChk(IDX_MOD_B, 32'(MOD_RST));
		wr(IDX_MOD_B, 32'h4);
		wr(IDX_DTM_B, 32'h5);
		wr(IDX_FQC_B, 32'hF2);
		wr(IDX_ENC_C, 32'h83);
		rdChk(IDX_MOD_B, 32'(MOD_RST));
		rdChk(IDX_DTM_B, 32'h0000_0FFF);
		rdChk(IDX_FQC_B, 32'h0);
		rdChk(IDX_ENC_C, 32'h0);
		axRd(6'h3F);
		chk(32'(r), 32'(RESP_SLVERR));
		// select on, edge-aligned, then stage modulus, deadtime, prescale
		wr(IDX_CTRL, 32'h09);
		wr(IDX_MOD_B, 32'h4);
		wr(IDX_DTM_B, 32'h5);
		wr(IDX_FQC_B, 32'h12);
		rdChk(IDX_FQC_B, 32'h12);
		settle();
		chk(32'(prescaleActB), 32'h0);
		chk(32'(deadtimeCyclesB), 32'h5);
		@(posedge clk);
		axRd(IDX_CTRL);
		wr(IDX_CTRL, 32'h0D);
		waitRel();
		settle();
		chk(32'(modulusActB), 32'h4);
		chk(32'(prescaleActB), 32'h1);
		chk(32'(deadtimeCyclesB), 32'h9);
		chk(32'(reloadReqB), 32'h1);
		@(posedge clk);
		period();
		chk(32'(n), 32'd16);
		wr(IDX_FQC_B, 32'hF2);
		period();
		period();
		chk(32'(n), 32'd128);
		rdChk(IDX_FQC_B, 32'hF3);
		wr(IDX_FQC_B, 32'hF3);
		rdChk(IDX_FQC_B, 32'hF2);
		chk(32'(reloadReqB), 32'h0);
		waitRel();
		axRd(IDX_FQC_B);
		waitRel();
		wr(IDX_FQC_B, 32'hF3);
		rdChk(IDX_FQC_B, 32'hF3);
		wr(IDX_CTRL, 32'h0B);
		wr(IDX_DTM_B, 32'h7);
		rdChk(IDX_DTM_B, 32'h5);
		wr(IDX_CNT_B, 32'h0);
		axRd(IDX_CNT_B);
		chk(32'(d[14:0] >= 1 && d[14:0] <= 4), 32'h1);
		chk(32'(d[31:15]), 32'h0);
		chk(32'(counterB >= 1 && counterB <= 4), 32'h1);
		// generator C: load okay then consumption by a reload
		rdChk(IDX_ENC_C, 32'h0);
		wr(IDX_ENC_C, 32'h02);
		rdChk(IDX_ENC_C, 32'h02);
		reloadC <= 1'b1;
		@(posedge clk);
		reloadC <= 1'b0;
		@(negedge clk);
		chk(32'(genCLoad), 32'h1);
		@(posedge clk);
		rdChk(IDX_ENC_C, 32'h0);
		wr(IDX_ENC_C, 32'h83);
		rdChk(IDX_ENC_C, 32'h83);
		reloadFlagC <= 1'b1;
		settle();
		chk(32'(genCEnable), 32'h1);
		chk(32'(reloadIrqC), 32'h1);
		@(posedge clk);
		wr(IDX_ENC_C, 32'h82);
		settle();
		chk(32'(reloadIrqC), 32'h0);
		@(posedge clk);
		wr(IDX_CTRL, 32'h0A);
		settle();
		chk(32'(genCEnable), 32'h0);
		@(posedge clk);
		rdChk(IDX_ENC_C, 32'h0);
		chk(32'(multiGenSelect), 32'h0);
		// center-aligned: half-cycle reloads double the reload rate
		wr(IDX_CTRL, 32'h01);
		chk(32'(multiGenSelect), 32'h1);
		wr(IDX_FQC_B, 32'h0A);
		period();
		chk(32'(n), 32'd8);
		wr(IDX_FQC_B, 32'h02);
		period();
		chk(32'(n), 32'd16);
		stop_test();
	end
endmodule
